/* include/dmt_map.svh */
// Address map, widths, reset values and timing counts of the data-memory block.
// Assumes inclusion by bare name from the design files.
`ifndef DMT_MAP_SVH
`define DMT_MAP_SVH

`define DMT_ADDR_IND 8'h00
`define DMT_ADDR_MP 8'h01
`define DMT_ADDR_ACC 8'h05
`define DMT_ADDR_TBLP 8'h07
`define DMT_ADDR_TABLE_HIGH_BYTE_LATCH 8'h08
`define DMT_ADDR_TABLE_POINTER_HIGH 8'h1f
`define DMT_GP_BASE 8'h20
`define DMT_GP_DEPTH 96
`define DMT_RST_BYTE 8'h00
`define DMT_RST_HI 7'h00
`define DMT_RST_PM 11'h000
`define DMT_LAST_PAGE 3'h7
`define DMT_TBL_CYCLES 2
`define DMT_PM_AW 11
`define DMT_PM_DW 15
`define DMT_HI_W 7

`endif

/* include/dmt_pkg.sv */
// Types shared by the data-memory and table-read logic.
// Assumes nothing of its surroundings.
package dmt_pkg;

    typedef enum logic [0:0] {
        DMT_IDLE = 1'b0,
        DMT_FETCH = 1'b1
    } dmt_tbl_state_e;

    typedef logic [7:0] dmt_byte_t;

endpackage : dmt_pkg

/* hw/dmt_table_addr.sv */
// Program-memory address former for the two table-read instructions.
// Assumes pointer and counter inputs are stable registers of the core.
`timescale 1ns/1ns
`default_nettype none
`include "dmt_map.svh"

module dmt_table_addr
    import dmt_pkg::*;
#(
    parameter bit HIGH_PTR_EN = 1'b0
) (
    // Selection
    input wire logic last_page,
    // Pointers
    input wire dmt_byte_t tblp,
    input wire dmt_byte_t table_pointer_high,
    input wire logic [2:0] pc_hi,
    // Address
    output logic [`DMT_PM_AW-1:0] pm_addr
);

    always_comb begin
        pm_addr[7:0] = tblp;
        if (last_page) begin
            pm_addr[10:8] = `DMT_LAST_PAGE;
        end else if (HIGH_PTR_EN) begin
            pm_addr[10:8] = table_pointer_high[2:0];
        end else begin
            pm_addr[10:8] = pc_hi;
        end
    end

endmodule : dmt_table_addr

`default_nettype wire

/* hw/dmt_data_memory.sv */
// Data memory, indirect addressing, accumulator and table-read sequencing.
// Assumes the instruction decoder drives all requests synchronous to clk.
//
// Summary of operation
// - Table address bits 7..0 come from the table pointer low register.
// - Last-page table reads force address bits 10..8 to all ones.
// - Current-page read without high pointer uses program counter bits 10..8.
// - Current-page read with high pointer uses high pointer bits 2..0.
// - Low byte goes to the operand; upper bits go to the table-high latch.
// - The table-high latch is read-only; only table reads change it.
// - Every table read takes two instruction cycles.
// - Data memory is 8-bit RAM with special and general areas consecutive.
// - Data addresses start at zero with special registers from there upward.
// - Unused and reserved data addresses read as zero.
// - Single-bit set and clear work on data memory except dedicated bits.
// - Some special registers are read-only; general locations are read-write.
// - The indirect port at address zero has no storage of its own.
// - Accesses to the indirect port go to the address in the pointer.
// - Pointer selecting the indirect port reads zero and ignores writes.
// - The memory pointer is an ordinary writable data-memory register.
// - The accumulator takes ALU results; no direct register-to-register move.
// - Pointer low at 07h, pointer high at 1Fh, table-high latch at 08h.
// - Program words are 15 bits; latch holds seven, its top bit reads zero.
// - With the high pointer option off the high pointer is ignored.
`timescale 1ns/1ns
`default_nettype none
`include "dmt_map.svh"

module dmt_data_memory
    import dmt_pkg::*;
#(
    parameter bit HIGH_PTR_EN = 1'b0,
    parameter int GP_DEPTH = `DMT_GP_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Data read port
    input wire logic rd_en,
    input wire dmt_byte_t rd_addr,
    output dmt_byte_t rd_data,
    // Data write port
    input wire logic wr_en,
    input wire dmt_byte_t wr_addr,
    input wire dmt_byte_t wr_data,
    // Bit set and clear
    input wire logic bit_en,
    input wire dmt_byte_t bit_addr,
    input wire logic [2:0] bit_idx,
    input wire logic bit_val,
    // Accumulator
    input wire logic acc_load,
    input wire dmt_byte_t acc_in,
    output dmt_byte_t acc,
    // Table read
    input wire logic tbl_start,
    input wire logic tbl_last_page,
    input wire dmt_byte_t tbl_dest,
    input wire logic [2:0] pc_hi,
    input wire logic [`DMT_PM_DW-1:0] pm_data,
    output logic [`DMT_PM_AW-1:0] pm_addr,
    output logic pm_rd,
    output logic fetch_hold,
    output logic tbl_busy
);

    localparam int IW = (GP_DEPTH > 1) ? $clog2(GP_DEPTH) : 1;

    dmt_tbl_state_e state;
    dmt_byte_t mp;
    dmt_byte_t tblp;
    dmt_byte_t table_pointer_high;
    logic [`DMT_HI_W-1:0] table_high_byte_latch;
    dmt_byte_t tbl_dest_q;
    dmt_byte_t gp_ram [GP_DEPTH];
    logic [`DMT_PM_AW-1:0] next_pm_addr;
    logic w_en;
    dmt_byte_t w_addr;
    dmt_byte_t w_data;
    dmt_byte_t bit_old;
    logic [`DMT_HI_W-1:0] pm_hi;
    logic [2:0] table_pointer_high_lo;

    assign pm_hi = pm_data[`DMT_PM_DW-1:8];
    assign table_pointer_high_lo = table_pointer_high[2:0];

    // Resolves an operand address through the indirect port.
    function automatic dmt_byte_t eff_addr(input dmt_byte_t a, input dmt_byte_t p);
        return (a == `DMT_ADDR_IND) ? p : a;
    endfunction : eff_addr

    // Tells whether an address falls in general-purpose memory.
    function automatic logic gp_hit(input dmt_byte_t a);
        dmt_byte_t off;
        off = a - `DMT_GP_BASE;
        return (a >= `DMT_GP_BASE) && (int'(off) < GP_DEPTH);
    endfunction : gp_hit

    // Returns the value a data address reads.
    function automatic dmt_byte_t peek(input dmt_byte_t a);
        dmt_byte_t off;
        off = a - `DMT_GP_BASE;
        unique case (a)
            `DMT_ADDR_MP: return mp;
            `DMT_ADDR_ACC: return acc;
            `DMT_ADDR_TBLP: return tblp;
            `DMT_ADDR_TABLE_HIGH_BYTE_LATCH: return {1'b0, table_high_byte_latch};
            `DMT_ADDR_TABLE_POINTER_HIGH: return table_pointer_high;
            default: begin
                if (gp_hit(a)) begin
                    return gp_ram[off[IW-1:0]];
                end
                return `DMT_RST_BYTE;
            end
        endcase
    endfunction : peek

    // Table address former.
    dmt_table_addr #(
        .HIGH_PTR_EN(HIGH_PTR_EN)
    ) u_addr (
        .last_page(tbl_last_page),
        .tblp(tblp),
        .table_pointer_high(table_pointer_high),
        .pc_hi(pc_hi),
        .pm_addr(next_pm_addr)
    );

    // Single write path: table result, then decoder write, then bit operation.
    always_comb begin
        w_en = 1'b0;
        w_addr = `DMT_RST_BYTE;
        w_data = `DMT_RST_BYTE;
        bit_old = `DMT_RST_BYTE;
        if (state == DMT_FETCH) begin
            w_en = 1'b1;
            w_addr = eff_addr(tbl_dest_q, mp);
            w_data = pm_data[7:0];
        end else if (wr_en) begin
            w_en = 1'b1;
            w_addr = eff_addr(wr_addr, mp);
            w_data = wr_data;
        end else if (bit_en) begin
            w_en = 1'b1;
            w_addr = eff_addr(bit_addr, mp);
            bit_old = peek(w_addr);
            w_data = bit_old;
            w_data[bit_idx] = bit_val;
        end
    end

    // Table-read sequencer.
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= DMT_IDLE;
        end else begin
            unique case (state)
                DMT_IDLE: begin
                    if (tbl_start) begin
                        state <= DMT_FETCH;
                    end
                end
                DMT_FETCH: begin
                    state <= DMT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pm_addr <= `DMT_RST_PM;
            tbl_dest_q <= `DMT_RST_BYTE;
        end else if (state == DMT_IDLE && tbl_start) begin
            pm_addr <= next_pm_addr;
            tbl_dest_q <= tbl_dest;
        end
    end

    assign pm_rd = (state == DMT_FETCH);
    assign fetch_hold = (state == DMT_FETCH);
    assign tbl_busy = (state == DMT_FETCH);

    // Table-high latch, changed only by a table read.
    always_ff @(posedge clk) begin
        if (srst) begin
            table_high_byte_latch <= `DMT_RST_HI;
        end else if (state == DMT_FETCH) begin
            table_high_byte_latch <= pm_hi;
        end
    end

    // Memory pointer.
    always_ff @(posedge clk) begin
        if (srst) begin
            mp <= `DMT_RST_BYTE;
        end else if (w_en && w_addr == `DMT_ADDR_MP) begin
            mp <= w_data;
        end
    end

    // Accumulator; an ALU result wins over a data write.
    always_ff @(posedge clk) begin
        if (srst) begin
            acc <= `DMT_RST_BYTE;
        end else if (acc_load) begin
            acc <= acc_in;
        end else if (w_en && w_addr == `DMT_ADDR_ACC) begin
            acc <= w_data;
        end
    end

    // Table pointers.
    always_ff @(posedge clk) begin
        if (srst) begin
            tblp <= `DMT_RST_BYTE;
        end else if (w_en && w_addr == `DMT_ADDR_TBLP) begin
            tblp <= w_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            table_pointer_high <= `DMT_RST_BYTE;
        end else if (w_en && w_addr == `DMT_ADDR_TABLE_POINTER_HIGH) begin
            table_pointer_high <= w_data;
        end
    end

    // General-purpose RAM above the special registers.
    for (genvar i = 0; i < GP_DEPTH; i++) begin : g_ram
        localparam dmt_byte_t GA = 8'(int'(`DMT_GP_BASE) + i);
        always_ff @(posedge clk) begin
            if (srst) begin
                gp_ram[i] <= `DMT_RST_BYTE;
            end else if (w_en && w_addr == GA) begin
                gp_ram[i] <= w_data;
            end
        end
    end

    // Registered read port.
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= `DMT_RST_BYTE;
        end else if (rd_en) begin
            rd_data <= peek(eff_addr(rd_addr, mp));
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (srst);

    sequence seq_tbl_go;
        state == DMT_IDLE && tbl_start;
    endsequence

    sequence seq_tbl_two;
        (tbl_busy && fetch_hold && pm_rd) ##1 !tbl_busy;
    endsequence

    AST_TBL_LOW: assert property (seq_tbl_go |=> pm_addr[7:0] == $past(tblp))
        else $error("Table low address differs from pointer low.");

    AST_TBL_LAST: assert property (
        seq_tbl_go and tbl_last_page |=> pm_addr[10:8] == `DMT_LAST_PAGE)
        else $error("Last-page read not in final page.");

    AST_TBL_PC: assert property (
        seq_tbl_go and !tbl_last_page and !HIGH_PTR_EN
        |=> pm_addr[10:8] == $past(pc_hi))
        else $error("Current-page read ignores program counter.");

    AST_TBL_HP: assert property (
        seq_tbl_go and !tbl_last_page and HIGH_PTR_EN
        |=> pm_addr[10:8] == $past(table_pointer_high_lo))
        else $error("Current-page read ignores high pointer.");

    AST_TBL_LATCH: assert property (state == DMT_FETCH |=> table_high_byte_latch == $past(pm_hi))
        else $error("Table-high latch not loaded.");

    AST_TBL_HOLD: assert property (state != DMT_FETCH |=> $stable(table_high_byte_latch))
        else $error("Table-high latch changed outside a table read.");

    AST_TBL_TWO: assert property (seq_tbl_go |=> seq_tbl_two)
        else $error("Table read did not take two cycles.");

    AST_IND_SELF: assert property (
        rd_en && rd_addr == `DMT_ADDR_IND && mp == `DMT_ADDR_IND
        |=> rd_data == `DMT_RST_BYTE)
        else $error("Self-selected indirect read not zero.");

    AST_IND_WR: assert property (
        state == DMT_IDLE && wr_en && wr_addr == `DMT_ADDR_IND && mp == `DMT_GP_BASE + 8'h01
        |=> gp_ram[1] == $past(wr_data))
        else $error("Indirect write not redirected.");

    AST_LATCH_TOP: assert property (
        rd_en && rd_addr == `DMT_ADDR_TABLE_HIGH_BYTE_LATCH |=> rd_data[7] == 1'b0)
        else $error("Table-high latch top bit not zero.");

endmodule : dmt_data_memory

`default_nettype wire

/* sim/dmt_pm_model.sv */
// Program memory model answering table fetches of the data-memory block.
// Assumes pm_addr is stable while pm_rd is high.
`timescale 1ns/1ns
`default_nettype none
`include "dmt_map.svh"

module dmt_pm_model (
    // Fetch request
    input wire logic pm_rd,
    input wire logic [`DMT_PM_AW-1:0] pm_addr,
    // Word
    output logic [`DMT_PM_DW-1:0] pm_data
);
    logic [`DMT_PM_DW-1:0] word;
    // Each word is 15 bits, built from its own address.
    assign word = {pm_addr[10:4], pm_addr[7:0] ^ 8'h3c};
    // Outside a fetch the bus shows the inverse, so stale data never passes.
    assign pm_data = pm_rd ? word : ~word;
endmodule : dmt_pm_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the data-memory block, with and without the high-pointer option.
// Assumes the program memory model answers while pm_rd is high.
`timescale 1ns/1ns
`default_nettype none
`include "dmt_map.svh"

module testbench
    import dmt_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, rd_en = 1'b0, wr_en = 1'b0, bit_en = 1'b0, bit_val = 1'b0;
    logic acc_load = 1'b0, tbl_start = 1'b0, tbl_last_page = 1'b0;
    logic [2:0] bit_idx = 3'h0, pc_hi = 3'h0;
    dmt_byte_t rd_addr = 8'h00, wr_addr = 8'h00, wr_data = 8'h00, bit_addr = 8'h00;
    dmt_byte_t acc_in = 8'h00, tbl_dest = 8'h00, rd_data, acc;
    logic [14:0] pm_data;
    logic [10:0] pm_addr, pm_addr_hp;
    logic pm_rd, fetch_hold, tbl_busy;
    int fail_count = 0, cmp_count = 0;
    logic [31:0] rows [11] = '{32'h205a205a, 32'h7fc37fc3, 32'h80118000, 32'h03220300,
        32'h08ff0800, 32'h01210121, 32'h00772177, 32'h01000100, 32'h00ee0000,
        32'h07060706, 32'h1f051f05};

    dmt_data_memory i_dmt_data_memory (.clk(clk), .srst(srst), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .bit_en(bit_en), .bit_addr(bit_addr), .bit_idx(bit_idx),
        .bit_val(bit_val), .acc_load(acc_load), .acc_in(acc_in), .acc(acc),
        .tbl_start(tbl_start), .tbl_last_page(tbl_last_page), .tbl_dest(tbl_dest),
        .pc_hi(pc_hi), .pm_data(pm_data), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .fetch_hold(fetch_hold), .tbl_busy(tbl_busy));
    dmt_pm_model i_dmt_pm_model (.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));
    // Second copy with the high-pointer option on; it sees the same stimulus.
    dmt_data_memory #(.HIGH_PTR_EN(1'b1)) i_dmt_data_memory_hp (.clk(clk), .srst(srst),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .bit_en(bit_en), .bit_addr(bit_addr), .bit_idx(bit_idx),
        .bit_val(bit_val), .acc_load(acc_load), .acc_in(acc_in), .acc(),
        .tbl_start(tbl_start), .tbl_last_page(tbl_last_page), .tbl_dest(tbl_dest),
        .pc_hi(pc_hi), .pm_data(pm_data), .pm_addr(pm_addr_hp), .pm_rd(),
        .fetch_hold(), .tbl_busy());

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic wr(input dmt_byte_t a, input dmt_byte_t d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd(input dmt_byte_t a, input dmt_byte_t exp);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        chk_val(rd_data, exp);
    endtask : rd

    task automatic bit_op(input dmt_byte_t a, input logic [2:0] i, input logic v);
        @(negedge clk);
        bit_en = 1'b1;
        bit_addr = a;
        bit_idx = i;
        bit_val = v;
        @(negedge clk);
        bit_en = 1'b0;
    endtask : bit_op

    // Start is held through the busy cycle and a write is tried there; both must be ignored.
    task automatic tbl(input logic last, input dmt_byte_t dest, input logic [2:0] pc,
        input logic [10:0] ea, input logic [10:0] eh);
        @(negedge clk);
        tbl_start = 1'b1;
        tbl_last_page = last;
        tbl_dest = dest;
        pc_hi = pc;
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = 8'h20;
        wr_data = 8'hff;
        chk_flag(tbl_busy, 1'b1);
        chk_flag(fetch_hold, 1'b1);
        chk_flag(pm_rd, 1'b1);
        chk_val(pm_addr, ea);
        chk_val(pm_addr_hp, eh);
        @(negedge clk);
        tbl_start = 1'b0;
        wr_en = 1'b0;
        chk_flag(tbl_busy, 1'b0);
    endtask : tbl

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        chk_val(acc, 8'h00);
        chk_val(pm_addr, 11'h000);
        chk_flag(tbl_busy, 1'b0);
        rd(8'h20, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i][31:24], rows[i][23:16]);
            rd(rows[i][15:8], rows[i][7:0]);
        end
        $display("table rows done");
        bit_op(8'h20, 3'h1, 1'b0);
        rd(8'h20, 8'h58);
        bit_op(8'h20, 3'h7, 1'b1);
        rd(8'h20, 8'hd8);
        bit_op(8'h08, 3'h0, 1'b1);
        rd(8'h08, 8'h00);
        $display("bit test done");
        @(negedge clk);
        acc_load = 1'b1;
        acc_in = 8'h3c;
        wr_en = 1'b1;
        wr_addr = 8'h05;
        wr_data = 8'h99;
        @(negedge clk);
        acc_load = 1'b0;
        wr_en = 1'b0;
        chk_val(acc, 8'h3c);
        rd(8'h05, 8'h3c);
        $display("accumulator test done");
        tbl(1'b1, 8'h21, 3'h2, 11'h706, 11'h706);
        rd(8'h21, 8'h3a);
        rd(8'h08, 8'h70);
        rd(8'h20, 8'hd8);
        wr(8'h01, 8'h22);
        tbl(1'b0, 8'h00, 3'h3, 11'h306, 11'h506);
        rd(8'h22, 8'h3a);
        rd(8'h08, 8'h30);
        $display("table read test done");
        for (int i = 0; i < 4; i++) begin
            dmt_byte_t lo;
            logic [2:0] hi;
            lo = 8'h40 + 8'(i);
            hi = i[0] ? 3'h7 : 3'h1 ^ 3'(i);
            wr(`DMT_ADDR_TBLP, lo);
            wr(`DMT_ADDR_TABLE_POINTER_HIGH, 8'hf9 ^ 8'(i));
            tbl(i[0], 8'h23, 3'h1, {i[0] ? 3'h7 : 3'h1, lo}, {hi, lo});
            rd(8'h23, lo ^ 8'h3c);
        end
        $display("address former test done");
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk_val(acc, 8'h00);
        chk_val(pm_addr, 11'h000);
        rd(8'h20, 8'h00);
        rd(8'h08, 8'h00);
        $display("second reset test done");
        results();
    end
endmodule : testbench
`default_nettype wire
